// ---- src/swp_defs.vh ----
`ifndef SWP_DEFS_VH
`define SWP_DEFS_VH
// Register byte offsets on the Wishbone bus
`define SWP_OFF_CTRL 6'h00
`define SWP_OFF_STAT 6'h04
`define SWP_OFF_MASK 6'h08
`define SWP_OFF_CMPL 6'h0c
`define SWP_OFF_CMPH 6'h10
`define SWP_OFF_RTCL 6'h14
`define SWP_OFF_RTCH 6'h18
`define SWP_OFF_INC 6'h1c
`define SWP_OFF_STATE 6'h20
// Retention memory fills 0x80-0xff, 32 words
`define SWP_OFF_MEM 8'h80
// Control register field positions
`define SWP_CTRL_SLEEP 0
`define SWP_CTRL_PIN_EN 1
`define SWP_CTRL_PIN_POL 2
`define SWP_CTRL_TMR_EN 3
`define SWP_CTRL_USB_EN 4
`define SWP_CTRL_SLOW_EN 5
// Status bit positions
`define SWP_ST_WAKE 0
`define SWP_ST_SLEPT 1
`define SWP_ST_PGRST 2
`define SWP_ST_WDTO 3
// Reset values
`define SWP_CTRL_RST 6'h00
// Clocks per slow tick, so sleeping time keeps main-clock pace
`define SWP_INC_RST 32'h00000640
`define SWP_WDT_RST 16'hffff
// Timing: slow tick at 31250 Hz from a 50 MHz clock
`define SWP_CLK_HZ 50000000
`define SWP_SLOW_HZ 31250
`define SWP_SLOW_DIV (`SWP_CLK_HZ / `SWP_SLOW_HZ)
// Steps spent in each intermediate state
`define SWP_STEP_CYC 8'd16
`endif

// ---- src/swp_dsmem.v ----
`timescale 1ns/1ps
// Small retention memory, 32 words of 32 bits
module swp_dsmem #(
  parameter AW = 5
) (
  input wire clk,
  input wire we,
  input wire [3:0] sel,
  input wire [AW-1:0] addr,
  input wire [31:0] wdat,
  output reg [31:0] rdat
);
  // Storage array, no reset so contents survive sleep
  reg [31:0] mem_r [0:(1<<AW)-1];
  integer i;

  // Byte-lane write
  always @(posedge clk) begin
    for (i = 0; i < 4; i = i + 1) begin
      if (we && sel[i]) begin
        mem_r[addr][i*8 +: 8] <= wdat[i*8 +: 8];
      end
    end
  end

  // Direct read; the bus mux registers it with ack
  always @* begin
    rdat = mem_r[addr];
  end
endmodule // swp_dsmem

// ---- src/swp_ctrl.v ----
`timescale 1ns/1ps
`include "swp_defs.vh"
// Contract
// R1 - Software or USB request starts sleep
// R2 - Requests only made while running
// R3 - Wake on USB, pin or timer
// R4 - Wake stimuli acted on only asleep
// R5 - Wake during sleep entry stays pending
// R6 - Always pass through intermediate states
// R7 - Pin wake edge selected by software
// R8 - Timer wakes at 64-bit compare match
// R9 - USB wake only when USB enabled
// R10 - Counter adds one per tick awake
// R11 - Optional slow clock while asleep
// R12 - Slow tick adds programmable increment
// R13 - Power-good loss in transition resets
// R14 - Quiescent powers down node, peripherals
// R15 - Software picks lowest-power sleep setup
// R16 - Retention memory kept through sleep
// R17 - Watchdog runs only while awake
// R18 - Switch back without losing count
module swp_ctrl #(
  parameter WDT_W = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg wb_ack_o,
  input wire wake_pin,
  input wire usb_sleep_req,
  input wire usb_wake_req,
  input wire pwr_good,
  output reg node_pwr_en,
  output reg periph_pwr_en,
  output reg sys_rst_req,
  output reg [1:0] pwr_state,
  output wire irq
);
  // Power states
  localparam ST_AWAKE = 2'd0;
  localparam ST_GO_SLEEP = 2'd1;
  localparam ST_ASLEEP = 2'd2;
  localparam ST_GO_WAKE = 2'd3;

  // Registers
  reg [5:0] ctrl_r;
  reg [3:0] stat_r;
  reg [3:0] mask_r;
  reg [63:0] cmp_r;
  reg [63:0] rtc_r;
  reg [31:0] inc_r;
  reg [1:0] state_r;
  reg [7:0] step_r;
  reg wake_pend_r;
  reg [WDT_W-1:0] wdt_r;
  reg [15:0] div_r;
  reg slow_tick_r;
  // Pin, USB and power-good synchronisers
  reg pin_s1_r, pin_s2_r, pin_s3_r;
  reg usbs_s1_r, usbs_s2_r;
  reg usbw_s1_r, usbw_s2_r;
  reg pg_s1_r, pg_s2_r;

  // 0x40-0x7f is unmapped, so force an offset that matches nothing
  wire [5:0] off = wb_adr_i[6] ? 6'h3f : wb_adr_i[5:0];
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land on the edge where the master sees ack
  wire wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  // Upper half of the byte window is retention memory
  wire mem_sel = wb_adr_i[7];
  wire [31:0] mem_rd;

  // Byte-lane merge used by the compare, counter and increment registers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // Retention memory instance
  swp_dsmem #(.AW(5)) u_mem (
    .clk(clk),
    .we(wr && mem_sel),
    .sel(wb_sel_i),
    .addr(wb_adr_i[6:2]),
    .wdat(wb_dat_i),
    .rdat(mem_rd)
  ); // R16

  // Edge of synchronised pin, polarity from control
  wire pin_rise = pin_s2_r && !pin_s3_r;
  wire pin_fall = !pin_s2_r && pin_s3_r;
  wire pin_ev = ctrl_r[`SWP_CTRL_PIN_EN] &&
    (ctrl_r[`SWP_CTRL_PIN_POL] ? pin_fall : pin_rise); // R7
  // At or past the compare: slow-tick steps can jump over it
  wire tmr_ev = ctrl_r[`SWP_CTRL_TMR_EN] && (rtc_r >= cmp_r); // R8
  wire usb_ev = ctrl_r[`SWP_CTRL_USB_EN] && usbw_s2_r; // R9
  wire wake_ev = pin_ev || tmr_ev || usb_ev; // R3
  wire sw_sleep = wr && off == `SWP_OFF_CTRL && !mem_sel && wb_sel_i[0] &&
    wb_dat_i[`SWP_CTRL_SLEEP];
  // Requests outside running are assumed absent; ignored anyway
  wire sleep_req = state_r == ST_AWAKE && (sw_sleep || usbs_s2_r); // R1 R2
  wire in_trans = state_r == ST_GO_SLEEP || state_r == ST_GO_WAKE;
  wire pg_fail = in_trans && !pg_s2_r; // R13
  wire slow_mode = state_r == ST_ASLEEP && ctrl_r[`SWP_CTRL_SLOW_EN];
  wire wdt_to = state_r == ST_AWAKE && wdt_r == {WDT_W{1'b0}};
  wire [3:0] ev_set = {wdt_to, pg_fail,
    state_r == ST_GO_SLEEP && step_r == 8'd0,
    state_r == ST_GO_WAKE && step_r == 8'd0};

  assign irq = |(stat_r & mask_r);

  // Two-flop synchronisers on all pins
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
      usbs_s1_r <= 1'b0;
      usbs_s2_r <= 1'b0;
      usbw_s1_r <= 1'b0;
      usbw_s2_r <= 1'b0;
      pg_s1_r <= 1'b0;
      pg_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= wake_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      usbs_s1_r <= usb_sleep_req;
      usbs_s2_r <= usbs_s1_r;
      usbw_s1_r <= usb_wake_req;
      usbw_s2_r <= usbw_s1_r;
      pg_s1_r <= pwr_good;
      pg_s2_r <= pg_s1_r;
    end
  end

  // Slow tick divider, the 31250 Hz time base
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= 16'h0000;
      slow_tick_r <= 1'b0;
    end else if (div_r == `SWP_SLOW_DIV - 1) begin
      div_r <= 16'h0000;
      slow_tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 16'h0001;
      slow_tick_r <= 1'b0;
    end
  end

  // Power state machine
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_AWAKE;
      step_r <= 8'h00;
      wake_pend_r <= 1'b0;
      sys_rst_req <= 1'b0;
    end else begin
      sys_rst_req <= pg_fail; // R13
      case (state_r)
        ST_AWAKE: begin
          wake_pend_r <= 1'b0; // R4
          if (sleep_req) begin
            state_r <= ST_GO_SLEEP; // R1 R6
            step_r <= `SWP_STEP_CYC;
          end
        end
        ST_GO_SLEEP: begin
          if (wake_ev) begin
            wake_pend_r <= 1'b1; // R5
          end
          if (pg_fail) begin
            state_r <= ST_AWAKE;
          end else if (step_r == 8'd0) begin
            state_r <= ST_ASLEEP;
          end else begin
            step_r <= step_r - 8'd1;
          end
        end
        ST_ASLEEP: begin
          // Pending wake serviced on arrival
          if (wake_ev || wake_pend_r) begin
            state_r <= ST_GO_WAKE; // R3 R5 R6
            step_r <= `SWP_STEP_CYC;
            wake_pend_r <= 1'b0;
          end
        end
        default: begin
          if (pg_fail) begin
            state_r <= ST_AWAKE;
          end else if (step_r == 8'd0) begin
            state_r <= ST_AWAKE;
          end else begin
            step_r <= step_r - 8'd1;
          end
        end
      endcase
    end
  end

  // Power enables follow the state, registered
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      node_pwr_en <= 1'b1;
      periph_pwr_en <= 1'b1;
      pwr_state <= ST_AWAKE;
    end else begin
      node_pwr_en <= state_r != ST_ASLEEP; // R14
      periph_pwr_en <= state_r == ST_AWAKE; // R14
      pwr_state <= state_r;
    end
  end

  // Real-time counter; one register means no loss on switch-back
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rtc_r <= 64'h0;
    end else if (wr && !mem_sel && off == `SWP_OFF_RTCL) begin
      rtc_r[31:0] <= merge(rtc_r[31:0], wb_dat_i, wb_sel_i);
    end else if (wr && !mem_sel && off == `SWP_OFF_RTCH) begin
      rtc_r[63:32] <= merge(rtc_r[63:32], wb_dat_i, wb_sel_i);
    end else if (slow_mode) begin
      if (slow_tick_r) begin
        rtc_r <= rtc_r + {32'h0, inc_r}; // R11 R12
      end
    end else begin
      rtc_r <= rtc_r + 64'h1; // R10 R18
    end
  end

  // Watchdog: counts down only when awake, reload on timeout
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdt_r <= `SWP_WDT_RST;
    end else if (state_r == ST_AWAKE) begin
      if (wdt_to) begin
        wdt_r <= `SWP_WDT_RST;
      end else if (slow_tick_r) begin
        wdt_r <= wdt_r - {{(WDT_W-1){1'b0}}, 1'b1}; // R17
      end
    end
  end

  // Register writes and sticky status, set wins over clear
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= `SWP_CTRL_RST;
      stat_r <= 4'h0;
      mask_r <= 4'h0;
      cmp_r <= 64'h0;
      inc_r <= `SWP_INC_RST;
    end else begin
      // Sleep bit is self-clearing; only the command matters
      if (wr && !mem_sel && off == `SWP_OFF_CTRL && wb_sel_i[0]) begin
        ctrl_r <= {wb_dat_i[5:1], 1'b0};
      end
      if (wr && !mem_sel && off == `SWP_OFF_MASK && wb_sel_i[0]) begin
        mask_r <= wb_dat_i[3:0];
      end
      if (wr && !mem_sel && off == `SWP_OFF_CMPL) begin
        cmp_r[31:0] <= merge(cmp_r[31:0], wb_dat_i, wb_sel_i);
      end
      if (wr && !mem_sel && off == `SWP_OFF_CMPH) begin
        cmp_r[63:32] <= merge(cmp_r[63:32], wb_dat_i, wb_sel_i);
      end
      if (wr && !mem_sel && off == `SWP_OFF_INC) begin
        inc_r <= merge(inc_r, wb_dat_i, wb_sel_i);
      end
      if (wr && !mem_sel && off == `SWP_OFF_STAT && wb_sel_i[0]) begin
        stat_r <= (stat_r & ~wb_dat_i[3:0]) | ev_set;
      end else begin
        stat_r <= stat_r | ev_set;
      end
    end
  end

  // Read mux, answered with one-cycle ack
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      if (mem_sel) begin
        wb_dat_o <= mem_rd; // R16
      end else if (off == `SWP_OFF_CTRL) begin
        wb_dat_o <= {26'h0, ctrl_r};
      end else if (off == `SWP_OFF_STAT) begin
        wb_dat_o <= {28'h0, stat_r};
      end else if (off == `SWP_OFF_MASK) begin
        wb_dat_o <= {28'h0, mask_r};
      end else if (off == `SWP_OFF_CMPL) begin
        wb_dat_o <= cmp_r[31:0];
      end else if (off == `SWP_OFF_CMPH) begin
        wb_dat_o <= cmp_r[63:32];
      end else if (off == `SWP_OFF_RTCL) begin
        wb_dat_o <= rtc_r[31:0];
      end else if (off == `SWP_OFF_RTCH) begin
        wb_dat_o <= rtc_r[63:32];
      end else if (off == `SWP_OFF_INC) begin
        wb_dat_o <= inc_r;
      end else if (off == `SWP_OFF_STATE) begin
        wb_dat_o <= {29'h0, wake_pend_r, state_r};
      end else begin
        wb_dat_o <= 32'h0;
      end
    end
  end

endmodule // swp_ctrl

// ---- verification/swp_chk_sva.sv ----
`timescale 1ns/1ps
// Sequencer and bus checks, top ports only
module swp_chk (
  input wire clk,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire pwr_good,
  input wire node_pwr_en,
  input wire periph_pwr_en,
  input wire sys_rst_req,
  input wire [1:0] pwr_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_no_jump_down: assert property (
    pwr_state == 2'd0 |=> pwr_state != 2'd2) else $error("skipped entry");
  a_no_jump_up: assert property (
    pwr_state == 2'd2 |=> pwr_state != 2'd0) else $error("skipped wake");
  // Entry lasts far beyond eight cycles
  a_entry_len: assert property (
    $past(pwr_state) == 2'd0 && pwr_state == 2'd1 |=> (pwr_state == 2'd1) [*8])
    else $error("entry too short");
  a_node_off: assert property (
    pwr_state == 2'd2 && $past(pwr_state) == 2'd2 |-> !node_pwr_en)
    else $error("node on asleep");
  a_periph_off: assert property (
    pwr_state != 2'd0 && $past(pwr_state) != 2'd0 |-> !periph_pwr_en)
    else $error("periph on");
  a_awake_pwr: assert property (
    pwr_state == 2'd0 && $past(pwr_state) == 2'd0 |-> node_pwr_en && periph_pwr_en)
    else $error("awake unpowered");
  a_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (
    $rose(wb_ack_o) |=> $fell(wb_ack_o)) else $error("ack too long");
  // Synchroniser delay fits inside the window
  a_pg_reset: assert property (
    ((pwr_state == 2'd1 || pwr_state == 2'd3) && !pwr_good) [*4] |-> ##[0:2] sys_rst_req)
    else $error("no reset");
  c_asleep: cover property (pwr_state == 2'd2);
  c_wake: cover property ($past(pwr_state) == 2'd2 && pwr_state == 2'd3);
  c_pg: cover property (sys_rst_req);
endmodule // swp_chk

// ---- verification/swp_far.sv ----
`timescale 1ns/1ps
// USB block, wake pin and supply monitor
module swp_far (
  input wire clk,
  input wire [1:0] pwr_state,
  input wire pin_lvl,
  input wire sleep_go,
  input wire wake_go,
  input wire pg_ok,
  output reg wake_pin = 1'b0,
  output reg usb_sleep_req = 1'b0,
  output reg usb_wake_req = 1'b0,
  output reg pwr_good = 1'b1
);
  // Lines move just after the edge
  always @(posedge clk) begin
    wake_pin <= pin_lvl;
    usb_wake_req <= wake_go;
    pwr_good <= pg_ok;
    // Standby asked only while running
    if (pwr_state != 2'd0)
      usb_sleep_req <= 1'b0;
    else if (sleep_go)
      usb_sleep_req <= 1'b1;
  end
endmodule // swp_far

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`include "swp_defs.vh"
module testbench;
  reg clk, sys_rst, we, cyc, stb; // Clock, reset, bus
  reg pin, slp, wk, pg; // Far-side commands
  reg [31:0] adr, wd, q, r0, t0; // Request, read data, snapshots
  reg [31:0] mem_v, inc_v; // Retained word, slow increment
  wire [31:0] rd;
  wire ack, wpin, usl, uwk, pgood, irq, rreq, nen, pen;
  wire [1:0] st;
  integer err_count, num_checks, cyc_n, i;
  swp_ctrl dut (.clk(clk), .sys_rst(sys_rst), .wb_adr_i(adr), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .wake_pin(wpin), .usb_sleep_req(usl), .usb_wake_req(uwk),
    .pwr_good(pgood), .node_pwr_en(nen), .periph_pwr_en(pen), .sys_rst_req(rreq),
    .pwr_state(st), .irq(irq));
  swp_far far (.clk(clk), .pwr_state(st), .pin_lvl(pin), .sleep_go(slp), .wake_go(wk),
    .pg_ok(pg), .wake_pin(wpin), .usb_sleep_req(usl), .usb_wake_req(uwk), .pwr_good(pgood));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc_n <= cyc_n + 1;
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Classic cycle; data taken at the ack edge
  task bus(input [31:0] a, input [31:0] d, input w);
    integer n;
    begin
      @(posedge clk);
      adr <= a;
      wd <= d;
      we <= w;
      cyc <= 1'b1;
      stb <= 1'b1;
      n = 0;
      @(posedge clk);
      while (ack !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge clk);
      end
      q = rd;
      t0 = cyc_n;
      cyc <= 1'b0;
      stb <= 1'b0;
      #1;
      if (n >= 50) begin
        chk(n, 0);
        report_and_stop;
      end
    end
  endtask
  // Bounded wait for a state
  task wst(input [1:0] s, input integer lim);
    integer n;
    begin
      n = 0;
      while (st !== s && n < lim) begin
        @(posedge clk);
        n = n + 1;
      end
      chk({30'h0, st}, {30'h0, s});
      if (st !== s)
        report_and_stop;
    end
  endtask
  // Control word: sleep, pin en, pin pol, timer, usb
  function [31:0] ctl(input sl, input pe, input pp, input te, input ue);
    ctl = {27'h0, ue, te, pp, pe, sl};
  endfunction
  initial begin
    sys_rst = 1'b1;
    {we, cyc, stb, pin, slp, wk, pg} = 7'h01;
    {adr, wd} = 64'h0;
    {err_count, num_checks, cyc_n} = 96'h0;
    i = $urandom(32'ha916);
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    bus(`SWP_OFF_CTRL, 32'h0, 1'b0);
    chk(q, {26'h0, `SWP_CTRL_RST});
    bus(`SWP_OFF_INC, 32'h0, 1'b0);
    chk(q, `SWP_INC_RST);
    // Unmapped space ignores writes
    bus(32'h3c, 32'hffffffff, 1'b1);
    bus(32'h3c, 32'h0, 1'b0);
    chk(q, 32'h0);
    mem_v = $urandom;
    bus(`SWP_OFF_MEM + 32'h7c, mem_v, 1'b1);
    bus(`SWP_OFF_MEM + 32'h7c, 32'h0, 1'b0);
    chk(q, mem_v);
    // Awake count gains one per cycle
    bus(`SWP_OFF_RTCL, 32'h0, 1'b0);
    r0 = q;
    i = t0;
    bus(`SWP_OFF_RTCL, 32'h0, 1'b0);
    chk(q - r0, t0 - i);
    // Timer wake at a random compare
    bus(`SWP_OFF_MASK, 32'hf, 1'b1);
    r0 = q + 32'd200 + ($urandom % 300);
    bus(`SWP_OFF_CMPH, 32'h0, 1'b1);
    bus(`SWP_OFF_CMPL, r0, 1'b1);
    bus(`SWP_OFF_CTRL, ctl(1, 0, 0, 1, 0), 1'b1);
    wst(2'd1, 10);
    wst(2'd2, 40);
    bus(`SWP_OFF_RTCL, 32'h0, 1'b0);
    chk(q < r0, 32'h1);
    wst(2'd3, 1000);
    wst(2'd0, 40);
    bus(`SWP_OFF_RTCL, 32'h0, 1'b0);
    chk(q > r0, 32'h1);
    // Interrupt raised, masked, cleared
    chk(irq, 32'h1);
    bus(`SWP_OFF_MASK, 32'h0, 1'b1);
    chk(irq, 32'h0);
    bus(`SWP_OFF_MASK, 32'hf, 1'b1);
    bus(`SWP_OFF_STAT, 32'hf, 1'b1);
    chk(irq, 32'h0);
    // Pin edge while awake has no effect
    bus(`SWP_OFF_CTRL, ctl(0, 1, 0, 0, 0), 1'b1);
    @(posedge clk) pin <= 1'b1;
    repeat (40) @(posedge clk);
    chk({30'h0, st}, 32'h0);
    // Both pin senses; USB wake dropped while USB is off
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clk) pin <= i[0];
      bus(`SWP_OFF_CTRL, ctl(0, 1, i[0], 0, 0), 1'b1);
      @(posedge clk) slp <= 1'b1;
      wst(2'd1, 20);
      slp <= 1'b0;
      wst(2'd2, 40);
      wk <= 1'b1;
      repeat (60) @(posedge clk);
      chk({30'h0, st}, 32'h2);
      pin <= ~i[0];
      wst(2'd3, 20);
      wst(2'd0, 40);
      wk <= 1'b0;
    end
    // Edge during entry waits for the asleep state
    bus(`SWP_OFF_CTRL, ctl(1, 1, 0, 0, 0), 1'b1);
    wst(2'd1, 10);
    @(posedge clk) pin <= 1'b1;
    wst(2'd2, 40);
    wst(2'd3, 4);
    wst(2'd0, 40);
    bus(`SWP_OFF_CTRL, ctl(1, 0, 0, 0, 1), 1'b1);
    wst(2'd2, 40);
    @(posedge clk) wk <= 1'b1;
    wst(2'd3, 20);
    wst(2'd0, 40);
    wk <= 1'b0;
    // Slow clock asleep: whole increments per slow tick
    inc_v = 32'h00000600 + ($urandom % 32'h100);
    bus(`SWP_OFF_INC, inc_v, 1'b1);
    bus(`SWP_OFF_CTRL, ctl(1, 1, 1, 0, 0) | 32'h20, 1'b1);
    wst(2'd2, 40);
    bus(`SWP_OFF_RTCL, 32'h0, 1'b0);
    r0 = q;
    i = t0;
    repeat (2 * `SWP_SLOW_DIV - 3) @(posedge clk);
    bus(`SWP_OFF_RTCL, 32'h0, 1'b0);
    chk(q - r0, inc_v * ((t0 - i) / `SWP_SLOW_DIV));
    r0 = q;
    @(posedge clk) pin <= 1'b0;
    wst(2'd3, 20);
    wst(2'd0, 40);
    bus(`SWP_OFF_RTCL, 32'h0, 1'b0);
    chk(q > r0, 32'h1);
    bus(`SWP_OFF_MEM + 32'h7c, 32'h0, 1'b0);
    chk(q, mem_v);
    // Supply loss in mid entry
    bus(`SWP_OFF_CTRL, ctl(1, 0, 0, 0, 0), 1'b1);
    wst(2'd1, 10);
    repeat (8) @(posedge clk);
    pg <= 1'b0;
    i = 0;
    while (rreq !== 1'b1 && i < 12) begin
      @(posedge clk);
      i = i + 1;
    end
    chk(rreq, 32'h1);
    pg <= 1'b1;
    wst(2'd0, 40);
    report_and_stop;
  end
endmodule // testbench
bind swp_ctrl swp_chk u_chk (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pwr_good(pwr_good), .node_pwr_en(node_pwr_en),
  .periph_pwr_en(periph_pwr_en), .sys_rst_req(sys_rst_req), .pwr_state(pwr_state));
